// >>> core/acc_clk_div.sv
// converter clock enable divider
`timescale 1ns/1ns
`default_nettype none
module acc_clk_div
	import acc_pkg::*;
#(
	parameter int CNT_W = 6
)(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// control bundle
	acc_conv_if.div  cv
);

	generate
		if (CNT_W < 6)
		begin : g_chk
			$error("acc_clk_div: CNT_W must hold a ratio of 32");
		end
	endgenerate

	function automatic logic [CNT_W-1:0] divRatio(input logic [2:0] sel);
		case (sel)
			DIV_BY_1:  divRatio = CNT_W'(1);
			DIV_BY_2:  divRatio = CNT_W'(2);
			DIV_BY_4:  divRatio = CNT_W'(4);
			DIV_BY_8:  divRatio = CNT_W'(8);
			DIV_BY_16: divRatio = CNT_W'(16);
			DIV_BY_32: divRatio = CNT_W'(32);
			// undefined codes fall back to the reset choice of /2
			default:   divRatio = CNT_W'(2);
		endcase
	endfunction

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] lastCnt;

	assign lastCnt = divRatio(cv.divSel) - CNT_W'(1);

	always_ff @(posedge clock)
	begin
		if (rst || !cv.run)
			cnt_q <= '0;
		else if (cnt_q >= lastCnt)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + CNT_W'(1);
	end

	assign cv.tick = cv.run && (cnt_q >= lastCnt);

endmodule
`default_nettype wire

// >>> core/acc_conv_if.sv
// bundle between control top, converter clock divider and sequencer
`timescale 1ns/1ns
`default_nettype none
interface acc_conv_if #(
	parameter int RES_BITS = 12
);
	logic [2:0]          divSel;
	logic                run;
	logic                tick;
	logic                go;
	logic                abort;
	logic                compIn;
	logic                busy;
	logic                done;
	logic                sampling;
	logic [RES_BITS-1:0] trial;
	logic [RES_BITS-1:0] result;

	modport div (input divSel, input run, output tick);
	modport seq (input tick, input go, input abort, input compIn,
		output busy, output done, output sampling, output trial, output result);
	modport top (output divSel, output run, output go, output abort, output compIn,
		input tick, input busy, input done, input sampling, input trial, input result);
endinterface
`default_nettype wire

// >>> core/acc_pkg.sv
// shared constants and types for the converter control block
package acc_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL0    = 8'h00;
	localparam logic [7:0] OFF_CTRL1    = 8'h04;
	localparam logic [7:0] OFF_PIN_SEL  = 8'h08;
	localparam logic [7:0] OFF_IRQ_CTRL = 8'h0C;
	localparam logic [7:0] OFF_RES_LOW  = 8'h10;
	localparam logic [7:0] OFF_RES_HIGH = 8'h14;

	// adc_ctrl0 fields
	localparam int unsigned CTRL0_START  = 7;
	localparam int unsigned CTRL0_BUSY_N = 6;
	localparam int unsigned CTRL0_POFF   = 5;
	localparam int unsigned CTRL0_CH_LSB = 0;

	// adc_ctrl1 fields
	localparam int unsigned CTRL1_REF     = 3;
	localparam int unsigned CTRL1_DIV_LSB = 0;

	// interrupt control fields
	localparam int unsigned IRQ_GLOBAL = 0;
	localparam int unsigned IRQ_MULTI  = 1;
	localparam int unsigned IRQ_ADC_EN = 2;
	localparam int unsigned IRQ_FLAG   = 3;

	// values after reset
	localparam logic       POFF_RST    = 1'b1;
	localparam logic [2:0] CH_RST      = 3'h0;
	localparam logic       REF_RST     = 1'b0;
	localparam logic [2:0] DIV_RST     = 3'h0;
	localparam logic [1:0] PIN_SEL_RST = 2'h3;
	localparam logic       BUSY_N_RST  = 1'b1;

	// converter clock divider codes
	localparam logic [2:0] DIV_BY_2  = 3'h0;
	localparam logic [2:0] DIV_BY_8  = 3'h1;
	localparam logic [2:0] DIV_BY_32 = 3'h2;
	localparam logic [2:0] DIV_BY_1  = 3'h4;
	localparam logic [2:0] DIV_BY_4  = 3'h5;
	localparam logic [2:0] DIV_BY_16 = 3'h6;

	// conversion phase lengths in converter clock periods
	localparam int unsigned SAMPLE_TICKS = 4;
	localparam int unsigned CONV_TICKS   = 12;

	typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT} acc_state_t;

endpackage

// >>> core/acc_sar_seq.sv
// sampling and successive approximation sequencer on converter clock enables
`timescale 1ns/1ns
`default_nettype none
module acc_sar_seq
	import acc_pkg::*;
#(
	parameter int RES_BITS = 12
)(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// control bundle
	acc_conv_if.seq  cv
);

	generate
		if (RES_BITS != CONV_TICKS)
		begin : g_chk
			$error("acc_sar_seq: one result bit per conversion clock");
		end
	endgenerate

	localparam logic [3:0] LAST_SAMPLE = 4'(SAMPLE_TICKS - 1);
	localparam logic [3:0] LAST_CONV   = 4'(CONV_TICKS - 1);
	localparam logic [RES_BITS-1:0] MSB_MASK = {1'b1, {(RES_BITS-1){1'b0}}};

	acc_state_t          state_q;
	logic [3:0]          cnt_q;
	logic [RES_BITS-1:0] trial_q;
	logic [RES_BITS-1:0] result_q;
	logic                done_q;
	logic [RES_BITS-1:0] curMask;
	logic [RES_BITS-1:0] trial_d;

	assign curMask = MSB_MASK >> cnt_q;
	// keep the bit under trial when the comparator says input is at or above it
	assign trial_d = (cv.compIn ? trial_q : (trial_q & ~curMask)) | (curMask >> 1);

	always_ff @(posedge clock)
	begin
		if (rst || cv.abort)
		begin
			state_q <= ST_IDLE;
			cnt_q   <= 4'h0;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
					if (cv.go)
					begin
						state_q <= ST_SAMPLE;
						cnt_q   <= 4'h0;
					end
				ST_SAMPLE:
					if (cv.tick)
					begin
						if (cnt_q == LAST_SAMPLE)
						begin
							state_q <= ST_CONVERT;
							cnt_q   <= 4'h0;
						end
						else
							cnt_q <= cnt_q + 4'h1;
					end
				ST_CONVERT:
					if (cv.tick)
					begin
						if (cnt_q == LAST_CONV)
							state_q <= ST_IDLE;
						else
							cnt_q <= cnt_q + 4'h1;
					end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			trial_q <= '0;
		else if (state_q == ST_SAMPLE)
			trial_q <= MSB_MASK;
		else if (state_q == ST_CONVERT && cv.tick)
			trial_q <= trial_d;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			result_q <= '0;
			done_q   <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (!cv.abort && state_q == ST_CONVERT && cv.tick && cnt_q == LAST_CONV)
			begin
				result_q <= trial_d;
				done_q   <= 1'b1;
			end
		end
	end

	assign cv.busy     = (state_q != ST_IDLE);
	assign cv.sampling = (state_q == ST_SAMPLE);
	assign cv.trial    = trial_q;
	assign cv.result   = result_q;
	assign cv.done     = done_q;

endmodule
`default_nettype wire

// >>> core/acc_top.sv
// converter control: registers, pin override, start, busy flag and interrupt
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - reference comes from supply or external pin per ref_source_sel
// - analog-selected pin is routed to converter, other pin functions off
// - pull-high on an analog-selected pin is disconnected
// - analog selection overrides the port direction setting
// - sampling lasts 4 converter clocks, then conversion 12
// - whole conversion is 16 converter clocks, processor keeps running
// - converter powered when adc_power_off is zero, fully off when one
// - busy flag goes low at end, result registers then valid
// - interrupt only with all three enables set and stack not full
// - result is 12 bits, full scale gives FFF
// - one code step is reference divided by 4096
// - thresholds shifted half step down, top at 1.5 step below reference
// - result split into low and high byte registers
// - writing 01 to adc_ctrl1 picks sys/8 and supply reference
// - writing 01 to analog_pin_sel makes channel zero pin analog
// - writing 00 to adc_ctrl0 powers on, channel zero, start clear
// - divider codes map to sys/2,/8,/32,/1,/4,/16
// - pin bit 0 selects port B channel zero, bit 1 port A channel one
// - end of conversion sets adc_irq_flag regardless of enables
// - start rising resets converter and clears busy flag
module acc_top
	import acc_pkg::*;
#(
	parameter int RES_BITS = 12
)(
	// clock and reset
	input  wire logic                clock,
	input  wire logic                rst,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// analog converter core
	input  wire logic                compIn,
	output logic                     convPowerDown,
	output logic                     refFromExtPin,
	output logic      [2:0]          channelSel,
	output logic                     sampleHold,
	output logic      [RES_BITS-1:0] dacCode,
	// shared pins: bit 0 port B channel zero pin, bit 1 port A channel one pin
	input  wire logic [1:0]          pullEnReq,
	input  wire logic [1:0]          portDirInReq,
	output logic      [1:0]          pullEnOut,
	output logic      [1:0]          portDirIn,
	output logic      [1:0]          digitalFuncEn,
	output logic      [1:0]          analogRouteEn,
	// interrupt
	input  wire logic                stackFull,
	output logic                     irqReq
);

	generate
		if (RES_BITS != 12)
		begin : g_chk
			$error("acc_top: result width is fixed at 12 bits");
		end
	endgenerate

	acc_conv_if #(.RES_BITS(RES_BITS)) cv ();

	acc_clk_div #(
		.CNT_W (6)
	) u_div (
		.clock (clock),
		.rst   (rst),
		.cv    (cv)
	);

	acc_sar_seq #(
		.RES_BITS (RES_BITS)
	) u_seq (
		.clock (clock),
		.rst   (rst),
		.cv    (cv)
	);

	// register state
	logic                startBit_q;
	logic                startPrev_q;
	logic                adcPowerOff_q;
	logic [2:0]          adcChannelSel_q;
	logic                refSourceSel_q;
	logic [2:0]          adcClkDivSel_q;
	logic [1:0]          analogPinBits_q;
	logic                globalIrqEnable_q;
	logic                multiFuncIrqEnable_q;
	logic                adcIrqEnable_q;
	logic                adcIrqFlag_q;
	logic                convBusyN_q;
	logic                irqReq_q;
	logic [31:0]         prdata_q;
	logic [1:0]          pullEn_q;
	logic [1:0]          portDir_q;
	logic [1:0]          digFunc_q;
	logic [1:0]          anaRoute_q;

	// bus decode
	logic                setupPhase;
	logic                accessPhase;
	logic                addrHit;
	logic                wrEn;
	logic [7:0]          wByte;
	logic [31:0]         readMux;
	logic [15:0]         resWide;
	logic                startRise;
	logic                startFall;
	logic                wrCtrl0;
	logic                wrCtrl1;
	logic                wrPinSel;
	logic                wrIrqCtrl;

	assign setupPhase  = psel && !penable;
	assign accessPhase = psel && penable;
	assign wrEn        = accessPhase && pwrite && pstrb[0] && addrHit;
	assign wByte       = pwdata[7:0];
	assign resWide     = 16'(cv.result);

	// one write strobe per writable register, shared by every writable field it holds
	assign wrCtrl0   = wrEn && (paddr == OFF_CTRL0);
	assign wrCtrl1   = wrEn && (paddr == OFF_CTRL1);
	assign wrPinSel  = wrEn && (paddr == OFF_PIN_SEL);
	assign wrIrqCtrl = wrEn && (paddr == OFF_IRQ_CTRL);

	always_comb
	begin
		addrHit = 1'b1;
		readMux = 32'h0000_0000;
		if (paddr == OFF_CTRL0)
		begin
			readMux[CTRL0_START]             = startBit_q;
			readMux[CTRL0_BUSY_N]            = convBusyN_q;
			readMux[CTRL0_POFF]              = adcPowerOff_q;
			readMux[CTRL0_CH_LSB +: 3]       = adcChannelSel_q;
		end
		else if (paddr == OFF_CTRL1)
		begin
			readMux[CTRL1_REF]               = refSourceSel_q;
			readMux[CTRL1_DIV_LSB +: 3]      = adcClkDivSel_q;
		end
		else if (paddr == OFF_PIN_SEL)
			readMux[1:0] = analogPinBits_q;
		else if (paddr == OFF_IRQ_CTRL)
		begin
			readMux[IRQ_GLOBAL] = globalIrqEnable_q;
			readMux[IRQ_MULTI]  = multiFuncIrqEnable_q;
			readMux[IRQ_ADC_EN] = adcIrqEnable_q;
			readMux[IRQ_FLAG]   = adcIrqFlag_q;
		end
		else if (paddr == OFF_RES_LOW)
			readMux[7:0] = resWide[7:0];
		else if (paddr == OFF_RES_HIGH)
			readMux[7:0] = resWide[15:8];
		else
			addrHit = 1'b0;
	end

	// read data is captured in the setup cycle and held through the access cycle
	always_ff @(posedge clock)
	begin
		if (rst)
			prdata_q <= 32'h0000_0000;
		else if (setupPhase && !pwrite)
			prdata_q <= readMux;
	end

	assign prdata  = prdata_q;
	assign pready  = 1'b1;
	assign pslverr = accessPhase && !addrHit;

	// adc_ctrl0
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			startBit_q      <= 1'b0;
			adcPowerOff_q   <= POFF_RST;
			adcChannelSel_q <= CH_RST;
		end
		else if (wrCtrl0)
		begin
			startBit_q      <= wByte[CTRL0_START];
			adcPowerOff_q   <= wByte[CTRL0_POFF];
			adcChannelSel_q <= wByte[CTRL0_CH_LSB +: 3];
		end
	end

	// adc_ctrl1
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			refSourceSel_q <= REF_RST;
			adcClkDivSel_q <= DIV_RST;
		end
		else if (wrCtrl1)
		begin
			refSourceSel_q <= wByte[CTRL1_REF];
			adcClkDivSel_q <= wByte[CTRL1_DIV_LSB +: 3];
		end
	end

	// analog_pin_sel
	always_ff @(posedge clock)
	begin
		if (rst)
			analogPinBits_q <= PIN_SEL_RST;
		else if (wrPinSel)
			analogPinBits_q <= wByte[1:0];
	end

	// interrupt enables
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			globalIrqEnable_q    <= 1'b0;
			multiFuncIrqEnable_q <= 1'b0;
			adcIrqEnable_q       <= 1'b0;
		end
		else if (wrIrqCtrl)
		begin
			globalIrqEnable_q    <= wByte[IRQ_GLOBAL];
			multiFuncIrqEnable_q <= wByte[IRQ_MULTI];
			adcIrqEnable_q       <= wByte[IRQ_ADC_EN];
		end
	end

	// flag set by hardware wins over a software clear in the same cycle
	always_ff @(posedge clock)
	begin
		if (rst)
			adcIrqFlag_q <= 1'b0;
		else if (cv.done)
			adcIrqFlag_q <= 1'b1;
		else if (wrIrqCtrl)
			adcIrqFlag_q <= wByte[IRQ_FLAG];
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			irqReq_q <= 1'b0;
		else
			irqReq_q <= adcIrqFlag_q && globalIrqEnable_q && multiFuncIrqEnable_q
				&& adcIrqEnable_q && !stackFull;
	end

	assign irqReq = irqReq_q;

	// start bit edges
	always_ff @(posedge clock)
	begin
		if (rst)
			startPrev_q <= 1'b0;
		else
			startPrev_q <= startBit_q;
	end

	assign startRise = startBit_q && !startPrev_q;
	assign startFall = !startBit_q && startPrev_q;

	// conversion control
	assign cv.divSel = adcClkDivSel_q;
	// the divider restarts at each start so the first sampling clock is a full period
	assign cv.run    = !adcPowerOff_q && !cv.go;
	// power-off or a fresh start rise drops any conversion in progress
	assign cv.abort  = startRise || adcPowerOff_q;
	assign cv.go     = startFall && !adcPowerOff_q;
	assign cv.compIn = compIn;

	// busy flag
	always_ff @(posedge clock)
	begin
		if (rst)
			convBusyN_q <= BUSY_N_RST;
		else if (cv.done)
			convBusyN_q <= 1'b0;
		else if (startRise)
			convBusyN_q <= 1'b0;
		else if (cv.go)
			convBusyN_q <= 1'b1;
	end

	// converter core drive
	assign convPowerDown = adcPowerOff_q;
	assign refFromExtPin = refSourceSel_q;
	assign channelSel    = adcChannelSel_q;
	assign sampleHold    = cv.sampling;
	assign dacCode       = cv.trial;

	// pin override, registered so pad controls change on a clean edge
	always_ff @(posedge clock)
	begin
		if (rst)
			pullEn_q <= 2'h0;
		else
			pullEn_q <= pullEnReq & ~analogPinBits_q;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			portDir_q <= 2'h3;
		else
			portDir_q <= portDirInReq | analogPinBits_q;
	end

	// analog pins lose their digital input path
	always_ff @(posedge clock)
	begin
		if (rst)
			digFunc_q <= 2'h0;
		else
			digFunc_q <= ~analogPinBits_q;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			anaRoute_q <= PIN_SEL_RST;
		else
			anaRoute_q <= analogPinBits_q;
	end

	assign pullEnOut     = pullEn_q;
	assign portDirIn     = portDir_q;
	assign digitalFuncEn = digFunc_q;
	assign analogRouteEn = anaRoute_q;

endmodule
`default_nettype wire

// >>> verif/acc_properties.sv
// port-level assertions for the converter control top
`timescale 1ns/1ns
`default_nettype none
module acc_properties
	import acc_pkg::*;
#(
	parameter int RES_BITS = 12
)(
	// clock and reset
	input wire logic                clock,
	input wire logic                rst,
	// bus
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [7:0]          paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [3:0]          pstrb,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	// converter core
	input wire logic                compIn,
	input wire logic                convPowerDown,
	input wire logic                refFromExtPin,
	input wire logic [2:0]          channelSel,
	input wire logic                sampleHold,
	input wire logic [RES_BITS-1:0] dacCode,
	// pins and interrupt
	input wire logic [1:0]          pullEnReq,
	input wire logic [1:0]          portDirInReq,
	input wire logic [1:0]          pullEnOut,
	input wire logic [1:0]          portDirIn,
	input wire logic [1:0]          digitalFuncEn,
	input wire logic [1:0]          analogRouteEn,
	input wire logic                stackFull,
	input wire logic                irqReq
);
	logic wrAcc;
	assign wrAcc = psel && penable && pwrite && pstrb[0];

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	property p_pull_off;
		pullEnOut == ($past(pullEnReq) & ~analogRouteEn);
	endproperty
	a_pull_off: assert property (p_pull_off) else $error("pull-high kept on analog pin");
	property p_dir_override;
		portDirIn == ($past(portDirInReq) | analogRouteEn);
	endproperty
	a_dir_override: assert property (p_dir_override) else $error("direction not forced");
	property p_digital_off;
		digitalFuncEn == ~analogRouteEn;
	endproperty
	a_digital_off: assert property (p_digital_off) else $error("digital function on");
	property p_stack_block;
		irqReq |-> !$past(stackFull);
	endproperty
	a_stack_block: assert property (p_stack_block) else $error("interrupt with full stack");
	property p_sample_len;
		$fell(sampleHold) && !convPowerDown && !$past(wrAcc) && !$past(wrAcc, 2)
			|-> $past(sampleHold, 4);
	endproperty
	a_sample_len: assert property (p_sample_len) else $error("sampling too short");
	property p_power_idle;
		convPowerDown && $past(convPowerDown) |-> !sampleHold;
	endproperty
	a_power_idle: assert property (p_power_idle) else $error("sampling while off");
	property p_ctrl0_write;
		wrAcc && paddr == OFF_CTRL0 |=>
			convPowerDown == $past(pwdata[CTRL0_POFF]) && channelSel == $past(pwdata[2:0]);
	endproperty
	a_ctrl0_write: assert property (p_ctrl0_write) else $error("control 0 not applied");
	property p_ref_write;
		wrAcc && paddr == OFF_CTRL1 |=> refFromExtPin == $past(pwdata[CTRL1_REF]);
	endproperty
	a_ref_write: assert property (p_ref_write) else $error("reference not applied");
	property p_pin_write;
		wrAcc && paddr == OFF_PIN_SEL |=> ##1 analogRouteEn == $past(pwdata[1:0], 2);
	endproperty
	a_pin_write: assert property (p_pin_write) else $error("pin select not applied");
	property p_trial_start;
		sampleHold && $past(sampleHold) |-> dacCode == 12'h800;
	endproperty
	a_trial_start: assert property (p_trial_start) else $error("trial not at midscale");
endmodule

bind acc_top acc_properties #(.RES_BITS(RES_BITS)) chk_u (.clock(clock), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .compIn(compIn),
	.convPowerDown(convPowerDown), .refFromExtPin(refFromExtPin), .channelSel(channelSel),
	.sampleHold(sampleHold), .dacCode(dacCode), .pullEnReq(pullEnReq),
	.portDirInReq(portDirInReq), .pullEnOut(pullEnOut), .portDirIn(portDirIn),
	.digitalFuncEn(digitalFuncEn), .analogRouteEn(analogRouteEn), .stackFull(stackFull),
	.irqReq(irqReq));
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the converter control top
`timescale 1ns/1ns
`default_nettype none
module testbench
	import acc_pkg::*;
;
	logic        clock, rst, psel, penable, pwrite, compIn, stackFull;
	logic        pready, pslverr, convPowerDown, refFromExtPin, sampleHold, irqReq, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [2:0]  channelSel;
	logic [11:0] dacCode;
	logic [1:0]  pullEnReq, portDirInReq, pullEnOut, portDirIn, digitalFuncEn, analogRouteEn;
	int          n_errors = 0;
	int          checks = 0;
	int          cyc = 0;
	int          shCnt = 0;

	acc_top dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .compIn(compIn), .convPowerDown(convPowerDown),
		.refFromExtPin(refFromExtPin), .channelSel(channelSel), .sampleHold(sampleHold),
		.dacCode(dacCode), .pullEnReq(pullEnReq), .portDirInReq(portDirInReq),
		.pullEnOut(pullEnOut), .portDirIn(portDirIn), .digitalFuncEn(digitalFuncEn),
		.analogRouteEn(analogRouteEn), .stackFull(stackFull), .irqReq(irqReq));

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// sampled mid-cycle so design updates have landed
	always @(negedge clock)
	begin
		cyc++;
		if (sampleHold === 1'b1)
			shCnt++;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				chk(0, 1, "bus timeout");
				give_verdict();
			end
			@(posedge clock);
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic test_reset();
		@(negedge clock);
		chk(analogRouteEn, 3, "pins after reset");
		chk(convPowerDown, 1, "power after reset");
		@(posedge clock);
		apb(1'b0, OFF_CTRL0, 0);
		chk(q, 32'h60, "control 0 after reset");
		$display("reset test done");
	endtask

	task automatic test_pins();
		pullEnReq <= 2'h3;
		portDirInReq <= 2'h0;
		for (int i = 1; i < 3; i++)
		begin
			apb(1'b1, OFF_PIN_SEL, i);
			@(negedge clock);
			chk(analogRouteEn, i, "route");
			chk(digitalFuncEn, 3 - i, "digital");
			chk(pullEnOut, 3 - i, "pull");
			chk(portDirIn, i, "direction");
			@(posedge clock);
		end
		apb(1'b0, 8'h18, 0);
		chk(q, 0, "unmapped read data");
		chk(err, 1, "unmapped read error");
		$display("pin test done");
	endtask

	task automatic test_setup();
		apb(1'b1, OFF_CTRL1, 32'h08);
		chk(refFromExtPin, 1, "external reference");
		apb(1'b1, OFF_CTRL1, 32'h01);
		chk(refFromExtPin, 0, "supply reference");
		apb(1'b1, OFF_CTRL0, 32'h00);
		chk({convPowerDown, channelSel}, 0, "power on channel zero");
		$display("setup test done");
	endtask

	task automatic conv(input logic [2:0] code, input int ratio, input logic cmp);
		int t0;
		int k;
		k = 0;
		apb(1'b1, OFF_CTRL1, {29'h0, code});
		apb(1'b1, OFF_CTRL0, 32'h00);
		apb(1'b1, OFF_PIN_SEL, 32'h01);
		compIn <= cmp;
		apb(1'b1, OFF_CTRL0, 32'h80);
		apb(1'b0, OFF_CTRL0, 0);
		chk(q[6], 0, "busy cleared by start");
		shCnt = 0;
		t0 = cyc;
		apb(1'b1, OFF_CTRL0, 32'h00);
		do
		begin
			apb(1'b0, OFF_CTRL0, 0);
			k++;
			if (k > 400)
			begin
				chk(0, 1, "conversion timeout");
				give_verdict();
			end
		end while (q[6] !== 1'b0 || shCnt < 4 * ratio);
		chk(shCnt, 4 * ratio, "sampling length");
		k = cyc - t0;
		chk(k >= 16 * ratio && k <= 17 * ratio + 12, 1, "conversion length");
		apb(1'b0, OFF_RES_LOW, 0);
		chk(q, cmp ? 32'hFF : 0, "result low");
		apb(1'b0, OFF_RES_HIGH, 0);
		chk(q, cmp ? 32'h0F : 0, "result high");
		apb(1'b0, OFF_IRQ_CTRL, 0);
		chk(q[IRQ_FLAG], 1, "end flag");
		chk(irqReq, 0, "interrupt held off");
	endtask

	task automatic test_div();
		logic [2:0] codes [6];
		codes = '{DIV_BY_1, DIV_BY_2, DIV_BY_4, DIV_BY_8, DIV_BY_16, DIV_BY_32};
		for (int i = 0; i < 6; i++)
		begin
			conv(codes[i], 1 << i, i[0]);
			apb(1'b1, OFF_IRQ_CTRL, 0);
		end
		$display("divider test done");
	endtask

	task automatic test_irq();
		apb(1'b1, OFF_IRQ_CTRL, 32'h07);
		stackFull <= 1'b1;
		conv(DIV_BY_1, 1, 1'b1);
		stackFull <= 1'b0;
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk(irqReq, 1, "interrupt raised");
		@(posedge clock);
		apb(1'b1, OFF_IRQ_CTRL, 32'h0B);
		@(negedge clock);
		chk(irqReq, 0, "interrupt gated by enable");
		@(posedge clock);
		$display("interrupt test done");
	endtask

	task automatic test_power();
		apb(1'b1, OFF_CTRL0, 32'h20);
		shCnt = 0;
		apb(1'b1, OFF_CTRL0, 32'hA0);
		apb(1'b1, OFF_CTRL0, 32'h20);
		repeat (40) @(posedge clock);
		chk({shCnt[7:0], convPowerDown}, 1, "no conversion while off");
		$display("power test done");
	endtask

	initial
	begin
		rst = 1'b1;
		{psel, penable, pwrite, compIn, stackFull} = 0;
		{paddr, pwdata, pullEnReq, portDirInReq} = 0;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		test_reset();
		test_pins();
		test_setup();
		test_div();
		test_irq();
		test_power();
		give_verdict();
	end
endmodule
`default_nettype wire
